/* File: sce_pkg.sv */
// package: opcodes, flag layout, reset values and carriers for the skip evaluator
// Operation
// RL1: all-set test skips when masked bits one
// RL2: all-clear test skips when masked bits zero
// RL3: bit tests read data memory only
// RL4: bit tests clear compare-only flag always
// RL5: bit tests ignore decimal, keep carry, zero
// RL6: comparisons use memory nibble and immediate
// RL7: equal test skips on exact match
// RL8: not-equal test skips on any difference
// RL9: greater-or-equal test skips when memory not below
// RL10: less-than test skips when memory strictly below
// RL11: comparisons ignore flags, keep carry, zero
// RL12: compare-only flag set blocks result writeback
// RL13: comparisons are unsigned, 0 to 15
// RL14: skipped instruction fetched but has no effect
package sce_pkg;
  // operation codes presented by the sequencer
  typedef enum logic [2:0] {
    SCE_OP_NONE                     = 3'h0,
    SCE_OP_SKIP_IF_ALL_SET          = 3'h1,
    SCE_OP_SKIP_IF_ALL_CLEAR        = 3'h2,
    SCE_OP_SKIP_IF_EQUAL            = 3'h3,
    SCE_OP_SKIP_IF_NOT_EQUAL        = 3'h4,
    SCE_OP_SKIP_IF_GREATER_OR_EQUAL = 3'h5,
    SCE_OP_SKIP_IF_LESS_THAN        = 3'h6
  } sce_op_t;

  // program status word bit positions
  localparam int unsigned PSW_CARRY_BIT   = 2;
  localparam int unsigned PSW_ZERO_BIT    = 1;
  localparam int unsigned PSW_COMPARE_BIT = 3;
  localparam int unsigned PSW_DECIMAL_BIT = 0;
  localparam logic [3:0]  PSW_RESET       = 4'h0;

  // one instruction offered to the evaluator
  typedef struct packed {
    logic       valid;
    sce_op_t    op;
    logic [3:0] memData;
    logic [3:0] operand;
  } sce_req_t;

  // registered state of the evaluator
  typedef struct packed {
    logic       skipPending;
    logic       skip;
    logic [3:0] psw;
  } sce_state_t;

  localparam sce_state_t STATE_RESET = '{skipPending: 1'b0, skip: 1'b0, psw: PSW_RESET};
endpackage

/* File: sce_skip_evaluator.sv */
// skip condition evaluator for the 4-bit core
`timescale 1ns/1ps
module sce_skip_evaluator (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire sce_pkg::sce_req_t req,
  input  wire logic             pswWrite,
  input  wire logic [3:0]       pswWriteData,
  input  wire logic             nextInstr,
  output logic                  skip,
  output logic                  suppressNext,
  output logic [3:0]            programStatusWord,
  output logic                  resultWriteEnable
);

  sce_pkg::sce_state_t stateFf;
  sce_pkg::sce_state_t nxtState;
  logic                cond;
  logic                isBitTest;

  // evaluate condition; only the memory nibble is ever tested
  always_comb begin
    cond      = 1'b0;
    isBitTest = 1'b0;
    case (req.op)
      sce_pkg::SCE_OP_SKIP_IF_ALL_SET: begin
        cond      = (req.memData & req.operand) == req.operand; // [RL1] [RL3]
        isBitTest = 1'b1;
      end
      sce_pkg::SCE_OP_SKIP_IF_ALL_CLEAR: begin
        cond      = (req.memData & req.operand) == 4'h0; // [RL2] [RL3]
        isBitTest = 1'b1;
      end
      sce_pkg::SCE_OP_SKIP_IF_EQUAL:       cond = req.memData == req.operand; // [RL6] [RL7]
      sce_pkg::SCE_OP_SKIP_IF_NOT_EQUAL:   cond = req.memData != req.operand; // [RL8]
      // unsigned nibble compares, decimal flag not consulted
      sce_pkg::SCE_OP_SKIP_IF_GREATER_OR_EQUAL: cond = req.memData >= req.operand; // [RL9] [RL13] [RL11]
      sce_pkg::SCE_OP_SKIP_IF_LESS_THAN:   cond = req.memData < req.operand; // [RL10] [RL13]
      default:                             cond = 1'b0;
    endcase
  end

  // next state: skip pulse, pending skip until next fetch, status word
  always_comb begin
    nxtState      = stateFf;
    nxtState.skip = req.valid && cond;
    if (pswWrite) begin
      nxtState.psw = pswWriteData;
    end
    // bit test wins over a same-cycle word write; carry and zero never touched
    if (req.valid && isBitTest) begin
      nxtState.psw[sce_pkg::PSW_COMPARE_BIT] = 1'b0; // [RL4] [RL5]
    end
    // set wins over the clear by the next fetch
    if (nextInstr) begin
      nxtState.skipPending = 1'b0;
    end
    if (req.valid && cond) begin
      nxtState.skipPending = 1'b1; // [RL14]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stateFf <= sce_pkg::STATE_RESET;
    end else begin
      stateFf <= nxtState;
    end
  end

  assign skip              = stateFf.skip;
  assign programStatusWord = stateFf.psw;
  // the fetched-but-skipped instruction is squashed
  assign suppressNext      = stateFf.skipPending && nextInstr; // [RL14]
  // compare-only blocks writeback; skipped instruction writes nothing either
  assign resultWriteEnable = !stateFf.psw[sce_pkg::PSW_COMPARE_BIT] && !suppressNext; // [RL12] [RL14]

  AST_ALL_SET: assert property (@(posedge ref_clk) disable iff (rst) // [RL1]
    (req.valid && req.op == sce_pkg::SCE_OP_SKIP_IF_ALL_SET)
      |=> skip == $past((req.memData & req.operand) == req.operand)) else $error("all-set skip wrong");
  AST_ALL_CLEAR: assert property (@(posedge ref_clk) disable iff (rst) // [RL2]
    (req.valid && req.op == sce_pkg::SCE_OP_SKIP_IF_ALL_CLEAR)
      |=> skip == $past((req.memData & req.operand) == 4'h0)) else $error("all-clear skip wrong");
  AST_CMP_CLEAR: assert property (@(posedge ref_clk) disable iff (rst) // [RL4]
    (req.valid && (req.op == sce_pkg::SCE_OP_SKIP_IF_ALL_SET || req.op == sce_pkg::SCE_OP_SKIP_IF_ALL_CLEAR))
      |=> !programStatusWord[sce_pkg::PSW_COMPARE_BIT]) else $error("compare flag not cleared");
  AST_BIT_FLAGS: assert property (@(posedge ref_clk) disable iff (rst) // [RL5]
    (req.valid && !pswWrite) |=> programStatusWord[2:0] == $past(programStatusWord[2:0]))
    else $error("carry or zero changed");
  AST_EQUAL: assert property (@(posedge ref_clk) disable iff (rst) // [RL7]
    (req.valid && req.op == sce_pkg::SCE_OP_SKIP_IF_EQUAL) |=> skip == $past(req.memData == req.operand))
    else $error("equal skip wrong");
  AST_NOT_EQUAL: assert property (@(posedge ref_clk) disable iff (rst) // [RL8]
    (req.valid && req.op == sce_pkg::SCE_OP_SKIP_IF_NOT_EQUAL) |=> skip == $past(req.memData != req.operand))
    else $error("not-equal skip wrong");
  AST_GE: assert property (@(posedge ref_clk) disable iff (rst) // [RL9]
    (req.valid && req.op == sce_pkg::SCE_OP_SKIP_IF_GREATER_OR_EQUAL)
      |=> skip == $past(req.memData >= req.operand))
    else $error("ge skip wrong");
  AST_LT: assert property (@(posedge ref_clk) disable iff (rst) // [RL10]
    (req.valid && req.op == sce_pkg::SCE_OP_SKIP_IF_LESS_THAN) |=> skip == $past(req.memData < req.operand))
    else $error("lt skip wrong");
  AST_CMP_PSW: assert property (@(posedge ref_clk) disable iff (rst) // [RL11]
    (req.valid && !pswWrite && !(req.op == sce_pkg::SCE_OP_SKIP_IF_ALL_SET || req.op == sce_pkg::SCE_OP_SKIP_IF_ALL_CLEAR))
      |=> $stable(programStatusWord)) else $error("comparison altered status word");
  AST_WRITEBACK: assert property (@(posedge ref_clk) disable iff (rst) // [RL12]
    programStatusWord[sce_pkg::PSW_COMPARE_BIT] |-> !resultWriteEnable) else $error("writeback under compare-only");
  AST_SQUASH: assert property (@(posedge ref_clk) disable iff (rst) // [RL14]
    (req.valid && req.op == sce_pkg::SCE_OP_SKIP_IF_EQUAL && req.memData == req.operand) ##1 nextInstr
      |-> suppressNext) else $error("skipped instruction not squashed");

endmodule

/* File: sce_seq_model.sv */
// sequencer model: fetches the instruction that follows each offered one
`timescale 1ns/1ps
module sce_seq_model (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic reqValid,
  output logic      nextInstr
);
  // successor fetch lands in the cycle after the request was taken;
  // launched on the rising edge so it is settled when the bench looks
  always @(posedge ref_clk or posedge rst) begin
    if (rst) nextInstr <= 1'b0;
    else nextInstr <= reqValid;
  end
endmodule

/* File: skip_condition_evaluator_tb_top.sv */
// testbench: bit tests, comparisons, refusal and squash of a skipped instruction
`timescale 1ns/1ps
module skip_condition_evaluator_tb_top;
  logic              ref_clk = 1'b0, rst = 1'b1, pswWrite = 1'b0, nextInstr, skip, suppressNext, resultWriteEnable;
  logic [3:0]        pswWriteData = 4'h0, programStatusWord;
  sce_pkg::sce_req_t req = '0;
  int                fails = 0, n_checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  sce_skip_evaluator sce_skip_evaluator_inst (.ref_clk(ref_clk), .rst(rst), .req(req), .pswWrite(pswWrite),
    .pswWriteData(pswWriteData), .nextInstr(nextInstr), .skip(skip), .suppressNext(suppressNext),
    .programStatusWord(programStatusWord), .resultWriteEnable(resultWriteEnable));
  sce_seq_model sce_seq_model_inst (.ref_clk(ref_clk), .rst(rst), .reqValid(req.valid), .nextInstr(nextInstr));
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic set_psw(input logic [3:0] v);
    pswWrite = 1'b1;
    pswWriteData = v;
    @(negedge ref_clk);
    pswWrite = 1'b0;
    @(negedge ref_clk);
  endtask
  // one instruction, then check skip, squash, writeback gate and status word
  task automatic issue(input sce_pkg::sce_op_t op, input logic [3:0] m, n, input logic s, input logic [3:0] p);
    req = '{1'b1, op, m, n};
    @(negedge ref_clk);
    req.valid = 1'b0;
    chk("skip", {3'h0, s}, {3'h0, skip});
    chk("suppressNext", {3'h0, s}, {3'h0, suppressNext});
    chk("resultWriteEnable", {3'h0, ~p[3] & ~s}, {3'h0, resultWriteEnable});
    chk("programStatusWord", p, programStatusWord);
    @(negedge ref_clk);
  endtask
  task automatic bit_tests();
    chk("resetPsw", 4'h0, programStatusWord);
    set_psw(4'he);
    chk("rweCompareOnly", 4'h0, {3'h0, resultWriteEnable});
    issue(sce_pkg::SCE_OP_SKIP_IF_ALL_SET, 4'hb, 4'hb, 1'b1, 4'h6);
    issue(sce_pkg::SCE_OP_SKIP_IF_ALL_SET, 4'hb, 4'hd, 1'b0, 4'h6);
    set_psw(4'h9);
    issue(sce_pkg::SCE_OP_SKIP_IF_ALL_CLEAR, 4'h9, 4'h6, 1'b1, 4'h1);
    set_psw(4'h8);
    issue(sce_pkg::SCE_OP_SKIP_IF_ALL_CLEAR, 4'h9, 4'he, 1'b0, 4'h0);
  endtask
  // every compare op against below, equal, above and the range ends
  task automatic comparisons();
    logic [3:0] mv[5] = '{4'h8, 4'h8, 4'h8, 4'h0, 4'hf};
    logic [3:0] iv[5] = '{4'h7, 4'h8, 4'h9, 4'hf, 4'h0};
    logic e;
    set_psw(4'hf);
    for (int k = 3; k <= 6; k++) begin
      for (int j = 0; j < 5; j++) begin
        e = (k == 3) ? mv[j] == iv[j] : (k == 4) ? mv[j] != iv[j] : (k == 5) ? mv[j] >= iv[j] : mv[j] < iv[j];
        issue(sce_pkg::sce_op_t'(k), mv[j], iv[j], e, 4'hf);
      end
    end
  endtask
  task automatic refused_op();
    set_psw(4'h8);
    issue(sce_pkg::SCE_OP_NONE, 4'h5, 4'h5, 1'b0, 4'h8);
    set_psw(4'h0);
    issue(sce_pkg::SCE_OP_SKIP_IF_EQUAL, 4'h5, 4'h5, 1'b1, 4'h0);
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    @(negedge ref_clk);
    bit_tests();
    comparisons();
    refused_op();
    wrap_up();
  end
  // hang guard: far above the cycles the scenarios need
  initial begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    wrap_up();
  end
endmodule
